/* File: tb_tws_unit.sv */
`timescale 1ns/1ps
module tb_tws_unit;
  import tws_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata, v;
  logic irq, k, sda_out, sda_oe_n, scl_out, scl_oe_n, scl_rel, sda_rel;
  int failures = 0;
  int check_count = 0;
  // open-drain wires with pull-ups
  wire logic scl_w = (scl_oe_n | scl_out) & scl_rel;
  wire logic sda_w = (sda_oe_n | sda_out) & sda_rel;
  always #5 mclk = ~mclk;
  tws_unit u_tws_unit (.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .irq_vector(), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n));
  tws_peer u_tws_peer (.scl_w(scl_w), .sda_w(sda_w), .scl_rel(scl_rel), .sda_rel(sda_rel));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] m,
    input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(n, e, rdata & m);
  endtask
  task automatic t_master();
    rchk("own", OWN_ADDR, 8'hFF, OWN_RST);
    rchk("ctrl", CTRL_ADDR, 8'hFF, 8'h00);
    wreg(CTRL_ADDR, 8'hE8);
    repeat (4) @(posedge mclk);
    chk("pins", 8'h05, {4'h0, sda_oe_n, sda_out, scl_oe_n, scl_out});
    for (int b = 0; b < 3; b++) begin
      u_tws_peer.sda_rel = b[0];
      wreg(CTRL_ADDR, b < 2 ? 8'h08 : 8'h28);
      wreg(CTRL_ADDR, 8'h28);
      repeat (8) @(posedge mclk);
      rchk("data_in", CTRL_ADDR, 8'h10, b > 0 ? 8'h10 : 8'h00);
    end
    wreg(SYS_ADDR, 8'h04);
    repeat (4) @(posedge mclk);
    chk("spe", 8'h03, {6'h0, sda_oe_n, scl_oe_n});
    u_tws_peer.sda_rel = 1'b1;
    wreg(SYS_ADDR, 8'h00);
    wreg(CTRL_ADDR, 8'h00);
  endtask
  task automatic t_rx();
    wreg(SYS_ADDR, 8'h03);
    u_tws_peer.start();
    u_tws_peer.put_byte(8'hAA, k);
    chk("ack", 8'h00, {7'h0, k});
    rchk("flag", CTRL_ADDR, 8'h03, 8'h01);
    chk("irq", 8'h01, {7'h0, irq});
    repeat (4) @(posedge mclk);
    #1 chk("stretch", 8'h00, {6'h0, scl_oe_n, scl_out});
    rchk("addr", DATA_ADDR, 8'hFF, 8'hAA);
    u_tws_peer.put_byte(8'h3C, k);
    rchk("flag2", CTRL_ADDR, 8'h01, 8'h01);
    rchk("byte", DATA_ADDR, 8'hFF, 8'h3C);
    rchk("again", DATA_ADDR, 8'h00, 8'h00);
    u_tws_peer.put_byte(8'h5A, k);
    chk("halted", 8'h01, {7'h0, k});
    wreg(CTRL_ADDR, 8'h04);
    wreg(CTRL_ADDR, 8'h00);
    u_tws_peer.stop();
  endtask
  task automatic t_tx();
    wreg(SYS_ADDR, 8'h01);
    u_tws_peer.start();
    u_tws_peer.put_byte(8'hAB, k);
    rchk("dir", CTRL_ADDR, 8'h03, 8'h03);
    chk("masked", 8'h00, {7'h0, irq});
    wreg(DATA_ADDR, 8'hC5);
    u_tws_peer.get_byte(1'b1, v);
    chk("tx", 8'hC5, v);
    rchk("nack", CTRL_ADDR, 8'h01, 8'h01);
    rchk("clr", DATA_ADDR, 8'h00, 8'h00);
    u_tws_peer.start();
    u_tws_peer.put_byte(8'h24, k);
    chk("other addr", 8'h01, {7'h0, k});
    u_tws_peer.stop();
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    t_master();
    t_rx();
    t_tx();
    end_of_test();
  end
  initial begin
    #300000;
    failures++;
    end_of_test();
  end
endmodule

/* File: tws_peer.sv */
`timescale 1ns/1ps
module tws_peer (
  input wire logic scl_w,
  input wire logic sda_w,
  output logic scl_rel,
  output logic sda_rel
);
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic start();
    sda_rel = 1'b1;
    #40 scl_rel = 1'b1;
    #80 sda_rel = 1'b0;
    #80 scl_rel = 1'b0;
  endtask
  task automatic bit_io(input logic b, output logic s);
    #40 sda_rel = b;
    #40 scl_rel = 1'b1;
    // slave may stretch the clock; bounded so a stuck line cannot hang us
    for (int i = 0; i < 3000 && !scl_w; i++) #10;
    #40 s = sda_w;
    #40 scl_rel = 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask
  task automatic get_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, s);
  endtask
  task automatic stop();
    #40 sda_rel = 1'b0;
    #40 scl_rel = 1'b1;
    #80 sda_rel = 1'b1;
  endtask
endmodule

/* File: tws_pkg.sv */
package tws_pkg;
  localparam logic [7:0] CTRL_ADDR = 8'h99;
  localparam logic [7:0] DATA_ADDR = 8'h9A;
  localparam logic [7:0] OWN_ADDR = 8'h9B;
  localparam logic [7:0] SYS_ADDR = 8'h9C;
  localparam logic [7:0] OWN_RST = 8'h55;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] SYS_RST = 8'h00;
  localparam logic [15:0] IRQ_VECTOR = 16'h003B;
  // control register fields
  localparam int C_DOUT = 7;
  localparam int C_DDRV = 6;
  localparam int C_COUT = 5;
  localparam int C_DIN = 4;
  localparam int C_MSEL = 3;
  localparam int C_IRST = 2;
  localparam int C_DIR = 1;
  localparam int C_FLAG = 0;
  // system register fields
  localparam int S_IEN = 0;
  localparam int S_GIE = 1;
  localparam int S_SPE = 2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RECV, ST_ACKOUT, ST_WAIT, ST_SEND, ST_ACKIN, ST_HALT
  } tws_state_t;
endpackage

/* File: tws_properties.sv */
`timescale 1ns/1ps
module tws_properties
  import tws_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic irq,
  input wire logic [15:0] irq_vector,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic scl_out,
  input wire logic scl_oe_n
);
  logic [7:0] sys_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // shadow copy, the register itself is not a port
  always_ff @(posedge mclk) begin
    if (srst) begin
      sys_r <= SYS_RST;
    end else if (wr && addr == SYS_ADDR) begin
      sys_r <= wdata;
    end
  end
  sequence s_mst(de);
    wr && addr == CTRL_ADDR && wdata[C_MSEL] && !sys_r[S_SPE] && wdata[C_DDRV] == de;
  endsequence
  AST_SCL_FOLLOW: assert property (s_mst(wdata[C_DDRV]) |-> ##2 !scl_oe_n &&
    scl_out == $past(wdata[C_COUT], 2)) else $error("clock pin off clock bit");
  AST_SDA_DRIVE: assert property (s_mst(1'b1) |-> ##2 !sda_oe_n &&
    sda_out == $past(wdata[C_DOUT], 2)) else $error("data pin off data bit");
  AST_SDA_FREE: assert property (s_mst(1'b0) |-> ##2 sda_oe_n)
    else $error("data pin not released");
  AST_RESET_PINS: assert property ($fell(srst) |-> sda_oe_n && scl_oe_n)
    else $error("pins driven after reset");
  AST_IRQ_MASK: assert property (!(sys_r[S_IEN] && sys_r[S_GIE]) |-> !irq)
    else $error("interrupt while masked");
  AST_DATA_CLEAR: assert property ((wr || rd) && addr == DATA_ADDR |-> ##1 !irq)
    else $error("interrupt kept after data access");
  AST_SPE_OFF: assert property (sys_r[S_SPE] && $past(sys_r[S_SPE], 2) |->
    sda_oe_n && scl_oe_n) else $error("pins driven while disabled");
  AST_VECTOR: assert property (irq_vector == IRQ_VECTOR)
    else $error("wrong vector");
endmodule
bind tws_unit tws_properties u_tws_properties (.mclk(mclk), .srst(srst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .irq(irq), .irq_vector(irq_vector), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .scl_out(scl_out), .scl_oe_n(scl_oe_n));

/* File: tws_unit.sv */
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Notes on behaviour
// - master-select bit set gives software master; clear gives hardware slave.
// - data-drive-enable set drives the data pin to the data-out bit.
// - in master mode the clock pin always follows the clock-out bit.
// - data-drive-enable clear releases the data pin for reception.
// - data-in bit captures data pin on each clock rising edge while data-drive-enable is clear.
// - after reset the unit is a hardware slave, master-select clear.
// - unit works only while the serial-peripheral enable bit is clear.
// - slave compares address with own-address register; bytes in data register.
// - slave waits for start; flag set after start, matching address, direction.
// - interrupt only when interface enable and global enable both set.
// - any data register access clears the byte-complete flag and interrupt; a byte event in the same cycle wins and leaves the flag set.
// - second data access for one event halts until interface reset bit.
// - interrupt vectors to the fixed address after each complete byte.
// - first byte shows received 7-bit address with direction bit.
// - direction flag holds master read/write bit; set means slave transmits.
// - after valid address slave holds clock low until flag cleared.
// - flag set after each acked byte; a nack also raises it.
// - byte events continue until stop or interface reset.
// - stop or nack ending a sequence returns slave to idle.
// - interface reset bit forces slave idle regardless of progress.
// - address and data events set the same flag, indistinguishable.
module tws_unit
  import tws_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq,
  output logic [15:0] irq_vector,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n
);
  logic [7:0] own_r;
  logic [7:0] dat_r;
  logic [7:0] sys_r;
  logic dout_r;
  logic ddrv_r;
  logic cout_r;
  logic din_r;
  logic msel_r;
  logic irst_r;
  logic dir_r;
  logic flag_r;
  logic used_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] ctrl_rd;
  logic [1:0] pins_s;
  logic sda_s2;
  logic sda_d;
  logic scl_s2;
  logic scl_d;
  tws_state_t state_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic match_r;
  logic active;
  logic slave_on;
  logic slave_live;
  logic master_live;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic wr_ctrl;
  logic wr_data;
  logic wr_own;
  logic wr_sys;
  logic dat_acc;
  logic rx_last;
  logic addr_hit;
  logic din_take;
  logic byte_evt;
  logic sda_low;
  logic hold_scl;

  // pins come from another domain; two flops before any logic reads them
  tws_sync #(
    .WIDTH(2)
  ) u_tws_sync (
    .mclk(mclk),
    .srst(srst),
    .din({sda_in, scl_in}),
    .dout(pins_s)
  );
  assign sda_s2 = pins_s[1];
  assign scl_s2 = pins_s[0];

  // one more stage gives the previous level for edges and bus conditions
  always_ff @(posedge mclk) begin
    if (srst) begin
      sda_d <= 1'b1;
      scl_d <= 1'b1;
    end else begin
      sda_d <= sda_s2;
      scl_d <= scl_s2;
    end
  end

  assign active = ~sys_r[S_SPE];
  assign slave_on = active & ~msel_r;
  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_c = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_c = scl_s2 & scl_d & ~sda_d & sda_s2;
  assign wr_ctrl = wr && addr == CTRL_ADDR;
  assign wr_data = wr && addr == DATA_ADDR;
  assign wr_own = wr && addr == OWN_ADDR;
  assign wr_sys = wr && addr == SYS_ADDR;
  assign dat_acc = (wr | rd) && addr == DATA_ADDR;
  assign slave_live = slave_on & ~irst_r;
  assign master_live = active & msel_r;
  assign rx_last = slave_live && scl_rise && state_r == ST_RECV &&
    cnt_r == BITS_PER_BYTE - 4'h1;
  assign addr_hit = sh_r[6:0] == own_r[6:0];
  // data-in only listens while the data driver is off
  assign din_take = master_live && !ddrv_r && scl_rise;
  assign hold_scl = slave_live && state_r == ST_WAIT && flag_r;
  assign ctrl_rd = {dout_r, ddrv_r, cout_r, din_r, msel_r, irst_r, dir_r, flag_r};

  // own address
  always_ff @(posedge mclk) begin
    if (srst) own_r <= OWN_RST;
    else if (wr_own) own_r <= wdata;
  end

  // enables and the pin-sharing bit
  always_ff @(posedge mclk) begin
    if (srst) sys_r <= SYS_RST;
    else if (wr_sys) sys_r <= wdata;
  end

  // software-owned control bits; bits 4, 1 and 0 are read-only
  always_ff @(posedge mclk) begin
    if (srst) begin
      dout_r <= CTRL_RST[C_DOUT];
      ddrv_r <= CTRL_RST[C_DDRV];
      cout_r <= CTRL_RST[C_COUT];
      msel_r <= CTRL_RST[C_MSEL];
      irst_r <= CTRL_RST[C_IRST];
    end else if (wr_ctrl) begin
      dout_r <= wdata[C_DOUT];
      ddrv_r <= wdata[C_DDRV];
      cout_r <= wdata[C_COUT];
      msel_r <= wdata[C_MSEL];
      irst_r <= wdata[C_IRST];
    end
  end

  // master data-in latch on clock rising edge while released
  always_ff @(posedge mclk) begin
    if (srst) din_r <= 1'b0;
    else if (din_take) din_r <= sda_s2;
  end

  // byte-complete event from the slave engine
  always_comb begin
    byte_evt = 1'b0;
    if (rx_last) begin
      // address byte only counts when it matches; data bytes always do
      if (match_r) byte_evt = 1'b1;
      else byte_evt = addr_hit;
    end
    if (slave_live && scl_rise && state_r == ST_ACKIN) byte_evt = 1'b1;
  end

  // flag: set wins over the clearing access
  always_ff @(posedge mclk) begin
    if (srst) begin
      flag_r <= 1'b0;
      used_r <= 1'b0;
    end else if (byte_evt) begin
      flag_r <= 1'b1;
      used_r <= 1'b0;
    end else if (irst_r) begin
      flag_r <= 1'b0;
      used_r <= 1'b0;
    end else if (dat_acc) begin
      flag_r <= 1'b0;
      used_r <= 1'b1;
    end
  end

  assign irq = flag_r & sys_r[S_IEN] & sys_r[S_GIE];
  assign irq_vector = IRQ_VECTOR;

  // slave engine
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      match_r <= 1'b0;
      dir_r <= 1'b0;
      dat_r <= DATA_RST;
    end else begin
      if (wr && addr == DATA_ADDR) dat_r <= wdata;
      if (!slave_on || irst_r) begin
        state_r <= ST_IDLE;
        match_r <= 1'b0;
      end else if (state_r == ST_HALT) begin
        state_r <= ST_HALT;
      end else if (dat_acc && used_r && !byte_evt) begin
        state_r <= ST_HALT;
      end else if (start_c) begin
        state_r <= ST_RECV;
        cnt_r <= 4'h0;
        match_r <= 1'b0;
      end else if (stop_c) begin
        state_r <= ST_IDLE;
        match_r <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: cnt_r <= 4'h0;
          ST_RECV: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_s2};
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == BITS_PER_BYTE - 4'h1) begin
                if (!match_r) begin
                  if (sh_r[6:0] == own_r[6:0]) begin
                    dat_r <= {sh_r[6:0], sda_s2};
                    dir_r <= sda_s2;
                    match_r <= 1'b1;
                  end else begin
                    state_r <= ST_IDLE;
                  end
                end else begin
                  dat_r <= {sh_r[6:0], sda_s2};
                end
              end
            end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
              state_r <= ST_ACKOUT;
            end
          end
          ST_ACKOUT: if (scl_fall) state_r <= ST_WAIT;
          ST_WAIT: begin
            // clock held low until software has serviced the byte
            if (!flag_r) begin
              cnt_r <= 4'h0;
              sh_r <= dat_r;
              state_r <= dir_r ? ST_SEND : ST_RECV;
            end
          end
          ST_SEND: begin
            if (scl_fall) begin
              sh_r <= {sh_r[6:0], 1'b1};
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == BITS_PER_BYTE - 4'h1) state_r <= ST_ACKIN;
            end
          end
          ST_ACKIN: begin
            if (scl_rise && sda_s2) match_r <= 1'b0;
            if (scl_fall) state_r <= match_r ? ST_WAIT : ST_IDLE;
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // pin drivers; open drain in slave mode, low enable means driving
  always_comb begin
    sda_low = 1'b0;
    if (slave_live) begin
      if (state_r == ST_ACKOUT) sda_low = 1'b1;
      if (state_r == ST_SEND) sda_low = ~sh_r[7];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) sda_out <= 1'b1;
    else if (master_live) sda_out <= dout_r;
    else sda_out <= 1'b0;
  end

  always_ff @(posedge mclk) begin
    if (srst) sda_oe_n <= 1'b1;
    else if (master_live) sda_oe_n <= ~ddrv_r;
    else sda_oe_n <= ~sda_low;
  end

  always_ff @(posedge mclk) begin
    if (srst) scl_out <= 1'b1;
    else if (master_live) scl_out <= cout_r;
    else scl_out <= 1'b0;
  end

  // stretching trades bus throughput for never losing a byte
  always_ff @(posedge mclk) begin
    if (srst) scl_oe_n <= 1'b1;
    else if (master_live) scl_oe_n <= 1'b0;
    else scl_oe_n <= ~hold_scl;
  end

  // read port, data one cycle after the strobe, unmapped reads zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd) begin
      case (addr)
        CTRL_ADDR: rdata_nxt = ctrl_rd;
        DATA_ADDR: rdata_nxt = dat_r;
        OWN_ADDR: rdata_nxt = own_r;
        SYS_ADDR: rdata_nxt = sys_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // zero outside the answer cycle so a bus or-tree needs no gating
  always_ff @(posedge mclk) begin
    if (srst) rdata_r <= 8'h00;
    else rdata_r <= rdata_nxt;
  end
  assign rdata = rdata_r;
endmodule

// two-flop synchroniser; resets to the idle-high level of the pins
module tws_sync #(
  parameter int WIDTH = 2
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;

  // only the second stage is read outside this module
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_r <= '1;
      dout <= '1;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule
